// file: core/see_pkg.sv
// Constants shared by the serial memory target: sizes, reset values and timing.
// Assumes a single 25 MHz clock that drives every design file.
// Function
// (R1) Master keeps write protect low from first data bit zero until programming ends.
// (R2) Write protect high after first data bit zero cancels the pending write.
// (R3) Write protect high while programming aborts it; touched locations become undefined.
// (R4) Start is data falling with clock high; nothing is answered before one.
// (R5) Every transaction ends with stop: data rising while clock is high.
// (R6) A write ended without stop, such as repeated start, programs nothing.
// (R7) Address byte carries four-bit type code, then three bits matched to select pins.
// (R8) Address byte bit zero: one selects read, zero selects write.
// (R9) Write protect high refuses all writes; low allows writes everywhere.
// (R10) After eight bits the sender releases data; receiver pulls low on ninth clock.
// (R11) Matching address byte is acknowledged; in write mode every later byte too.
// (R12) Read sends eight bits, samples acknowledge, continues or waits for stop.
// (R13) Byte or page programming begins at stop and lasts at most 5 ms.
// (R14) Page write takes up to 32 bytes; only low five address bits advance.
// (R15) More than 32 bytes wrap within the page and replace earlier bytes.
// (R16) After reads the counter is last plus one; after writes the last address.
// (R17) Sequential read continues while acknowledged and may cover all 4096 words.
// (R18) Master reads anywhere by address write phase, repeated start, read address.
// (R19) Master ends a read with high acknowledge then stop.
// (R20) Write protect is ignored from start until first data bit zero is sampled.
// (R21) A write cancelled by write protect returns to standby at once; the code stays in the write phase, acknowledging bytes, until stop.
// (R22) Data sampled on clock rising edge; output changes only after falling edge.
// (R23) While programming, commands are ignored and the address is not acknowledged.
// (R24) Start followed by stop cancels the command; counter undefined after read.
// (R25) Word address is two bytes, high first; only low twelve bits are used.
package see_pkg;
	localparam int ADDR_W = 12;
	localparam int PAGE_W = 5;
	localparam logic [31:0] PAGE_BYTES = 32'd32;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [5:0] PIN_INIT = 6'h03;
	localparam int PROG_TIME_US = 5000;
	localparam int MCLK_KHZ = 25000;
	localparam int PROG_CYC = PROG_TIME_US * MCLK_KHZ / 1000;
endpackage

// file: core/see_mem_if.sv
// Interface carrying one memory port: address, write data, strobe and read data.
// Assumes the owner of the ctl side drives all three requests every cycle.
`timescale 1ns/1ps
interface see_mem_if #(parameter int AW = 12);
	logic [AW-1:0] addr;
	logic [7:0] wdata;
	logic we;
	logic [7:0] rdata;
	modport ctl (output addr, output wdata, output we, input rdata);
	modport mem (input addr, input wdata, input we, output rdata);
endinterface

// file: core/see_sync.sv
// Two-stage synchroniser for a group of pins.
// Assumes the inputs are asynchronous to mclk; only the second stage is visible.
`timescale 1ns/1ps
module see_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic nrst,
	// Pins and their synchronised copy.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// Both stages reset to the idle level of the pins.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			meta_r <= INIT;
			q <= INIT;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// file: core/see_mem.sv
// Single-port byte memory with registered read data.
// Assumes one access per cycle; a write returns the old contents.
`timescale 1ns/1ps
module see_mem #(
	parameter int AW = 12
) (
	// Clock.
	input wire logic mclk,
	// Memory port.
	see_mem_if.mem bus
);
	logic [7:0] cells [2**AW];

	// Write when strobed, read every cycle into the output register.
	always_ff @(posedge mclk)
	begin
		if (bus.we)
		begin
			cells[bus.addr] <= bus.wdata;
		end
		bus.rdata <= cells[bus.addr];
	end
endmodule

// file: core/see_top.sv
// Two-wire bus target for a 4096 x 8 nonvolatile memory with a 32-byte page buffer.
// Assumes scl, sda_in, wp and the select pins are asynchronous pins sampled on mclk,
// and that scl phases last many mclk periods.
`timescale 1ns/1ps
module see_top #(
	parameter int unsigned PROG_CYCLES = see_pkg::PROG_CYC,
	parameter logic [3:0] DEV_TYPE = 4'h5 // Arbitrary value.
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic nrst,
	// Bus pins, open drain data.
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	// Strap and protect pins.
	input wire logic select_pin_bit0,
	input wire logic select_pin_bit1,
	input wire logic select_pin_bit2,
	input wire logic wp,
	// Status.
	output logic prog_busy
);
	import see_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_AHI, ST_ALO, ST_WDATA, ST_RDATA, ST_WAIT}
		see_state_e;

	see_state_e st_r, st_nxt;
	logic [5:0] pin_s;
	logic scl_d_r, sda_d_r;
	logic [3:0] bcnt_r;
	logic [6:0] sh_r;
	logic ack_slot_r, ack_r, got_r, pend_r;
	logic [3:0] ahi_r;
	logic [ADDR_W-1:0] acnt_r;
	logic [31:0] vmask_r;
	logic [31:0] pcnt_r;
	logic [7:0] tx_r;

	see_mem_if #(.AW(ADDR_W)) arr_if ();
	see_mem_if #(.AW(PAGE_W)) pbuf_if ();

	// ------------------------------------------------------------
	// Pin sampling and bus conditions
	// ------------------------------------------------------------

	// All pins pass two flops before use.
	see_sync #(.W(6), .INIT(PIN_INIT)) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.d({select_pin_bit2, select_pin_bit1, select_pin_bit0, wp, sda_in, scl}),
		.q(pin_s)
	);

	// Edge and condition decode on the synchronised lines.
	wire scl_s = pin_s[0];
	wire sda_s = pin_s[1];
	wire wp_s = pin_s[2];
	wire [2:0] sel_s = pin_s[5:3];
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s; // R4
	wire stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s; // R5
	wire active = (st_r != ST_IDLE) && (st_r != ST_WAIT);
	wire bit_rise = scl_rise & active & ~ack_slot_r & (bcnt_r < BIT_ACK); // R22
	wire byte_done = bit_rise & (bcnt_r == BIT_LAST);
	wire ack_enter = scl_fall & active & ~ack_slot_r & (bcnt_r == BIT_ACK);
	wire ack_rise = scl_rise & ack_slot_r;
	wire ack_fall = scl_fall & ack_slot_r;
	wire [7:0] rx_byte = {sh_r, sda_s};
	wire dev_hit = (rx_byte[7:1] == {DEV_TYPE, sel_s}) & ~prog_busy; // R7 R23
	wire rd_sent = ack_enter & (st_r == ST_RDATA) & ~ack_r;
	wire nack = ack_rise & (st_r == ST_RDATA) & ~ack_r & sda_s; // R12

	// ------------------------------------------------------------
	// Write path and programming decode
	// ------------------------------------------------------------

	// Only the in-page bits advance; the first byte uses the given address.
	wire wr_byte = byte_done & (st_r == ST_WDATA);
	wire first_d0 = wr_byte & ~got_r;
	wire [4:0] widx = got_r ? acnt_r[4:0] + 5'h01 : acnt_r[4:0]; // R14 R15
	wire [31:0] pstep = pcnt_r - 32'h00000001;
	wire [4:0] pidx = pstep[4:0];
	wire prog_wr = prog_busy & (pcnt_r != 32'h00000000) & (pstep < PAGE_BYTES) & vmask_r[pidx];
	wire prog_end = prog_busy & ((pcnt_r == PROG_CYCLES - 1) | wp_s); // R13 R3

	// Memory ports: programming owns the array, reads follow the counter.
	assign arr_if.addr = prog_busy ? {acnt_r[11:5], pidx} : acnt_r;
	assign arr_if.wdata = pbuf_if.rdata;
	assign arr_if.we = prog_wr;
	assign pbuf_if.addr = prog_busy ? pcnt_r[4:0] : widx;
	assign pbuf_if.wdata = rx_byte;
	assign pbuf_if.we = wr_byte; // R15

	see_mem #(.AW(ADDR_W)) u_array (
		.mclk(mclk),
		.bus(arr_if.mem)
	);

	see_mem #(.AW(PAGE_W)) u_page (
		.mclk(mclk),
		.bus(pbuf_if.mem)
	);

	// ------------------------------------------------------------
	// Transaction state machine
	// ------------------------------------------------------------

	// Start and stop override everything; bytes advance the phase.
	always_comb
	begin
		st_nxt = st_r;
		if (start_cond)
			st_nxt = ST_DEV; // R4 R24
		else if (stop_cond)
			st_nxt = ST_IDLE; // R5 R21
		else if (nack)
			st_nxt = ST_WAIT; // R12
		else if (byte_done)
		begin
			unique case (st_r)
				ST_DEV: st_nxt = !dev_hit ? ST_WAIT : (rx_byte[0] ? ST_RDATA : ST_AHI); // R8
				ST_AHI: st_nxt = ST_ALO;
				ST_ALO: st_nxt = ST_WDATA;
				ST_WDATA: st_nxt = ST_WDATA;
				ST_RDATA: st_nxt = ST_RDATA;
				ST_IDLE: st_nxt = ST_IDLE;
				ST_WAIT: st_nxt = ST_WAIT;
			endcase
		end
	end

	// State and line history.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			st_r <= ST_IDLE;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	// Bit counter, receive shifter and acknowledge slot.
	always_ff @(posedge mclk)
	begin
		if (!nrst || start_cond || stop_cond)
		begin
			bcnt_r <= 4'h0;
			sh_r <= 7'h00;
			ack_slot_r <= 1'b0;
			ack_r <= 1'b0;
		end
		else
		begin
			if (bit_rise)
			begin
				bcnt_r <= bcnt_r + 4'h1;
				sh_r <= rx_byte[6:0];
			end
			if (byte_done)
				ack_r <= (st_r == ST_DEV) ? dev_hit : (st_r != ST_RDATA); // R11
			if (ack_enter)
				ack_slot_r <= 1'b1;
			if (ack_fall)
			begin
				ack_slot_r <= 1'b0;
				bcnt_r <= 4'h0;
			end
		end
	end

	// Open-drain data: ack, read bits, release; changed only on falling scl, start or stop.
	always_ff @(posedge mclk)
	begin
		if (!nrst || start_cond || stop_cond)
			sda_oe_n <= 1'b1;
		else if (ack_enter)
			sda_oe_n <= ~ack_r; // R10 R11
		else if (ack_fall && st_r == ST_RDATA)
			sda_oe_n <= arr_if.rdata[7]; // R12 R17
		else if (ack_fall || (st_r != ST_RDATA && !ack_slot_r))
			sda_oe_n <= 1'b1; // R10 Keeps the acknowledge for the whole ninth clock.
		else if (scl_fall && !ack_slot_r && bcnt_r != 4'h0 && bcnt_r < BIT_ACK)
			sda_oe_n <= tx_r[3'(BIT_LAST - bcnt_r)]; // R22
	end

	// Output byte is latched at the start of each read byte.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			tx_r <= 8'h00;
			sda_out <= 1'b0;
		end
		else if (ack_fall && st_r == ST_RDATA)
			tx_r <= arr_if.rdata;
	end

	// ------------------------------------------------------------
	// Address counter and write buffer bookkeeping
	// ------------------------------------------------------------

	// Word address high then low; written data bytes step the page bits only, read bytes the whole counter.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			ahi_r <= 4'h0;
			acnt_r <= 12'h000;
		end
		else if (byte_done && st_r == ST_AHI)
			ahi_r <= rx_byte[3:0]; // R25
		else if (byte_done && st_r == ST_ALO)
			acnt_r <= {ahi_r, rx_byte}; // R25
		else if (wr_byte)
			acnt_r[4:0] <= widx; // R14 R16
		else if (rd_sent)
			acnt_r <= acnt_r + 12'h001; // R16 R17
	end

	// Pending write: armed at the first data bit zero if unprotected.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			got_r <= 1'b0;
			pend_r <= 1'b0;
			vmask_r <= 32'h00000000;
		end
		else if (start_cond && !prog_busy)
		begin
			got_r <= 1'b0; // R6
			pend_r <= 1'b0; // R6
			vmask_r <= 32'h00000000;
		end
		else
		begin
			if (wr_byte)
			begin
				got_r <= 1'b1;
				vmask_r[widx] <= 1'b1;
			end
			if (first_d0)
				pend_r <= ~wp_s; // R20 R9
			else if (wp_s || stop_cond)
				pend_r <= 1'b0; // R2 R21
		end
	end

	// ------------------------------------------------------------
	// Programming cycle
	// ------------------------------------------------------------

	// Copy buffered bytes into the page, then hold busy for the full time unless write protect rises.
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			prog_busy <= 1'b0;
			pcnt_r <= 32'h00000000;
		end
		else if (stop_cond && pend_r && !wp_s && !prog_busy)
		begin
			prog_busy <= 1'b1; // R13
			pcnt_r <= 32'h00000000;
		end
		else if (prog_end)
			prog_busy <= 1'b0; // R3
		else if (prog_busy)
			pcnt_r <= pcnt_r + 32'h00000001;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	idle_hold_a: assert property (st_r == ST_IDLE && !start_cond |=> st_r == ST_IDLE) // R4
		else $error("Target left idle without a start");
	stop_idle_a: assert property (stop_cond && !start_cond |=> st_r == ST_IDLE) // R5
		else $error("Stop did not return to idle");
	restart_drop_a: assert property (start_cond && !prog_busy |=> !pend_r) // R6
		else $error("Repeated start kept pending write");
	busy_nack_a: assert property (byte_done && st_r == ST_DEV && prog_busy
		|=> st_r == ST_WAIT ##1 sda_oe_n) // R23
		else $error("Address answered while programming");
	wp_cancel_a: assert property (pend_r && wp_s && !first_d0 |=> !pend_r) // R2
		else $error("Write protect did not cancel pending write");
	wp_abort_a: assert property (prog_busy && wp_s |=> !prog_busy) // R3
		else $error("Write protect did not abort programming");
	prog_start_a: assert property (stop_cond && pend_r && !wp_s && !prog_busy
		|=> prog_busy && pcnt_r == 32'h00000000) // R13
		else $error("Programming did not start at stop");
	page_fixed_a: assert property (wr_byte |=> acnt_r[11:5] == $past(acnt_r[11:5])) // R14
		else $error("Page bits moved during page write");
	read_step_a: assert property (rd_sent |=> acnt_r == $past(acnt_r) + 12'h001) // R16
		else $error("Read did not advance the counter");
	ack_drive_a: assert property (ack_enter && ack_r |=> !sda_oe_n) // R10
		else $error("Acknowledge not driven");
	nack_wait_a: assert property (nack && !start_cond && !stop_cond |=> st_r == ST_WAIT) // R12
		else $error("No acknowledge did not end the read");
	oe_fall_a: assert property (!$stable(sda_oe_n) |-> $past(scl_fall || start_cond
		|| stop_cond || ack_enter)) // R22
		else $error("Data changed outside a falling clock");

	prog_cov: cover property (stop_cond && pend_r ##1 prog_busy);
	seq_cov: cover property (rd_sent ##[1:1000] rd_sent);
	cancel_cov: cover property (pend_r && wp_s);
	busy_cov: cover property (byte_done && st_r == ST_DEV && prog_busy);
endmodule

// file: verif/see_bus_master.sv
// Behavioural two-wire bus master that clocks the bus and pulls the data line.
// Assumes a pull-up on data and a device that shows its own pull through an enable.
`timescale 1ns/1ps
module see_bus_master (
	// Clock.
	input wire logic mclk,
	// Bus wires.
	input wire logic dev_oe_n,
	output logic scl,
	output logic sda
);
	logic m_pull = 1'b0;
	initial scl = 1'b1;

	// The wire is low when either party pulls; otherwise the pull-up wins.
	assign sda = (m_pull || !dev_oe_n) ? 1'b0 : 1'b1;

	// Every change lands one nanosecond after a clock edge.
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One bit: data set while the clock is low, sampled in mid high phase.
	task automatic bit_x(input logic b, output logic r);
		m_pull = !b;
		tick(8);
		scl = 1'b1;
		tick(4);
		r = sda;
		tick(4);
		scl = 1'b0;
		tick(4);
	endtask

	// Data falls while the clock is high.
	task automatic start_c();
		m_pull = 1'b0;
		tick(8);
		scl = 1'b1;
		tick(8);
		m_pull = 1'b1;
		tick(8);
		scl = 1'b0;
		tick(4);
	endtask

	// Data rises while the clock is high, then the bus is left idle.
	task automatic stop_c();
		m_pull = 1'b1;
		tick(8);
		scl = 1'b1;
		tick(8);
		m_pull = 1'b0;
		tick(8);
	endtask

	// Sends eight bits, most significant first, then releases for the answer.
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(d[i], r);
		end
		bit_x(1'b1, r);
		ack = !r;
	endtask

	// Reads eight bits; a high answer on the last byte ends the read.
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(last, r);
	endtask
endmodule

// file: verif/see_top_tb.sv
// Self-checking bench for the serial memory target, driven through a bus master model.
// Assumes the master model in verif and a short programming time set by parameter.
`timescale 1ns/1ps
module see_top_tb;
	import see_pkg::*;
	localparam int PROG = 300;
	localparam logic [3:0] DEV = 4'h5; // Arbitrary value.
	localparam logic [2:0] SEL = 3'h5;
	typedef struct packed {logic [15:0] wa; logic [7:0] d; logic wp_a; logic wp_b;} see_row_s;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic wp = 1'b0;
	logic scl;
	logic sda;
	logic sda_oe_n;
	logic prog_busy;
	logic sda_o;
	logic a;
	int err_total = 0;
	int checks = 0;
	logic [7:0] mdl [0:4095];
	logic [7:0] got [0:31];
	see_row_s rows [0:5];

	always #20 mclk = ~mclk;

	see_top #(.PROG_CYCLES(PROG), .DEV_TYPE(DEV)) dut (
		.mclk(mclk), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_n(sda_oe_n),
		.select_pin_bit0(SEL[0]), .select_pin_bit1(SEL[1]), .select_pin_bit2(SEL[2]),
		.wp(wp), .prog_busy(prog_busy)
	);
	see_bus_master m (.mclk(mclk), .dev_oe_n(sda_oe_n), .scl(scl), .sda(sda));

	// ------------------------------------------------------------
	// Helper tasks
	// ------------------------------------------------------------
	// Compares one value and counts the comparison.
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Start, write-mode address and the two word address bytes.
	task automatic cmd(input logic [15:0] wa);
		logic k;
		m.start_c();
		m.wbyte({DEV, SEL, 1'b0}, k);
		chk("addr ack", k, 1'b1);
		m.wbyte(wa[15:8], k);
		chk("high ack", k, 1'b1);
		m.wbyte(wa[7:0], k);
		chk("low ack", k, 1'b1);
	endtask

	// Random or current read of n bytes into got.
	task automatic rd(input logic rnd, input logic [15:0] wa, input int n);
		logic k;
		if (rnd)
			cmd(wa);
		m.start_c();
		m.wbyte({DEV, SEL, 1'b1}, k);
		chk("read ack", k, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			m.rbyte(i == n - 1, got[i]);
		end
		m.stop_c();
	endtask

	// Waits a bounded time for programming to finish.
	task automatic wait_idle();
		int n;
		n = 0;
		while (prog_busy !== 1'b0 && n < PROG + 20)
		begin
			m.tick(1);
			n++;
		end
		chk("busy ends", n < PROG + 20, 1'b1);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rows = '{'{16'h0000, 8'h11, 1'b0, 1'b0}, '{16'hFFFF, 8'hEE, 1'b0, 1'b0},
			'{16'hF800, 8'h3C, 1'b1, 1'b0}, '{16'h0800, 8'hC3, 1'b0, 1'b1},
			'{16'h0000, 8'h77, 1'b1, 1'b1}, '{16'h0ABC, 8'hA5, 1'b0, 1'b0}};
		m.tick(20);
		nrst = 1'b1;
		chk("idle release", sda_oe_n, 1'b1);
		chk("idle busy", prog_busy, 1'b0);
		chk("drive level", sda_o, 1'b0);
		m.tick(4);
		// Byte writes under each protect pattern, each read back at random.
		foreach (rows[i])
		begin
			wp = rows[i].wp_a;
			cmd(rows[i].wa);
			wp = 1'b0;
			m.wbyte(rows[i].d, a);
			chk("data ack", a, 1'b1);
			wp = rows[i].wp_b;
			m.stop_c();
			wp = 1'b0;
			chk("busy", prog_busy, !rows[i].wp_b);
			if (!rows[i].wp_b)
				mdl[rows[i].wa[11:0]] = rows[i].d;
			wait_idle();
			rd(1'b1, rows[i].wa, 1);
			chk("byte read", got[0], mdl[rows[i].wa[11:0]]);
		end
		// Poll during programming, then abort it with the protect pin.
		cmd(16'h0123);
		m.wbyte(8'h42, a);
		m.stop_c();
		m.start_c();
		m.wbyte({DEV, SEL, 1'b0}, a);
		chk("poll ack", a, 1'b0);
		m.stop_c();
		chk("still busy", prog_busy, 1'b1);
		wp = 1'b1;
		m.tick(6);
		chk("abort", prog_busy, 1'b0);
		wp = 1'b0;
		// Foreign type code and foreign select bits.
		for (int i = 0; i < 2; i++)
		begin
			m.start_c();
			m.wbyte(i ? {DEV, SEL ^ 3'h2, 1'b1} : {DEV ^ 4'h8, SEL, 1'b0}, a);
			chk("foreign addr", a, 1'b0);
			m.stop_c();
		end
		// A write ended by a repeated start programs nothing.
		cmd(16'h0ABC);
		m.wbyte(8'h00, a);
		m.start_c();
		m.stop_c();
		chk("no program", prog_busy, 1'b0);
		rd(1'b1, 16'h0ABC, 1);
		chk("kept byte", got[0], mdl[12'hABC]);
		// Page write of 34 bytes from offset 30, wrapping inside the page.
		cmd(16'h07FE);
		for (int i = 0; i < 34; i++)
		begin
			m.wbyte(8'h80 + i[7:0], a);
			chk("page ack", a, 1'b1);
			mdl[{7'h3F, 5'(30 + i)}] = 8'h80 + i[7:0];
		end
		m.stop_c();
		wait_idle();
		rd(1'b0, 16'h0000, 1);
		chk("after write", got[0], mdl[12'h7FF]);
		rd(1'b1, 16'h07E0, 32);
		for (int j = 0; j < 32; j++)
		begin
			chk("page byte", got[j], mdl[12'h7E0 + j]);
		end
		rd(1'b0, 16'h0000, 1);
		chk("after read", got[0], mdl[12'h800]);
		// A reset in mid-programming returns the outputs to idle and frees the bus.
		cmd(16'h0040);
		m.wbyte(8'h5A, a);
		m.stop_c();
		chk("busy before reset", prog_busy, 1'b1);
		nrst = 1'b0;
		m.tick(3);
		chk("reset busy", prog_busy, 1'b0);
		chk("reset release", sda_oe_n, 1'b1);
		nrst = 1'b1;
		m.tick(4);
		m.start_c();
		m.wbyte({DEV, SEL, 1'b0}, a);
		chk("ack after reset", a, 1'b1);
		m.stop_c();
		close_out();
	end

	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		repeat (90000) @(posedge mclk);
		err_total++;
		close_out();
	end
endmodule
